// [verilog/dtc_pkg.sv]
package dtc_pkg;
	// =========================================
	// Register map.
	localparam logic [3:0] DTC_ADDR_OPTIONS = 4'h0;
	localparam logic [3:0] DTC_ADDR_STATUS = 4'h1;
	localparam int DTC_ADDR_W = 4;
	// =========================================
	// Field positions of the options register.
	localparam int DTC_BIT_WS_HI = 5;
	localparam int DTC_BIT_WS_LO = 4;
	localparam int DTC_BIT_PM_EXTRA = 3;
	localparam int DTC_BIT_PAGE_DIS = 2;
	localparam int DTC_BIT_PAR_DIS = 1;
	localparam int DTC_BIT_RAS_OFF = 0;
	localparam logic [7:0] DTC_OPT_RESET = 8'h00;
	localparam logic [7:0] DTC_OPT_WMASK = 8'h3F;
	// =========================================
	// Timing: double-rate clock periods per wait state.
	localparam logic [1:0] DTC_PERIODS_PER_WAIT = 2'h2;
	localparam logic [2:0] DTC_WAIT_BASE_HIT0 = 3'h0;
	localparam logic [2:0] DTC_WAIT_BASE_HIT1 = 3'h1;
	localparam logic [2:0] DTC_WAIT_BASE_HIT2 = 3'h2;
	localparam logic [2:0] DTC_WAIT_MISS_00 = 3'h2;
	localparam logic [2:0] DTC_WAIT_MISS_01 = 3'h3;
	localparam logic [2:0] DTC_WAIT_MISS_1X = 3'h4;

	typedef struct packed {
		logic [1:0] wait_select;
		logic page_miss_extra_wait;
		logic page_mode_disable;
		logic parity_disable;
		logic row_strobe_shutoff;
	} dtc_cfg_t;
endpackage

// [verilog/dtc_cfg_if.sv]
`timescale 1ns/1ps
interface dtc_cfg_if;
	logic [1:0] wait_select;
	logic page_miss_extra_wait;
	logic cycle_start;
	logic page_miss;
	logic busy;
	logic wait_done;
	modport ctrl (output wait_select, output page_miss_extra_wait, output cycle_start, output page_miss,
		input busy, input wait_done);
	modport cnt (input wait_select, input page_miss_extra_wait, input cycle_start, input page_miss,
		output busy, output wait_done);
endinterface

// [verilog/dtc_wait_counter.sv]
`timescale 1ns/1ps
module dtc_wait_counter (
	input wire logic clk,
	input wire logic rstn,
	dtc_cfg_if.cnt cfg
);
	import dtc_pkg::*;

	typedef struct packed {
		logic busy;
		logic done;
		logic [2:0] waits;
		logic [1:0] sub;
	} dtc_cnt_t;

	dtc_cnt_t s_r;
	dtc_cnt_t s_nxt;

	// =========================================
	// Wait-state lookup.
	function automatic logic [2:0] dtc_waits(input logic [1:0] sel, input logic miss, input logic extra);
		logic [2:0] w;
		w = 3'h0;
		if (miss) begin
			unique casez (sel)
				2'b00: w = extra ? DTC_WAIT_MISS_01 : DTC_WAIT_MISS_00;
				2'b01: w = DTC_WAIT_MISS_01;
				default: w = extra ? 3'(DTC_WAIT_MISS_1X + 3'h1) : DTC_WAIT_MISS_1X;
			endcase
		end else begin
			unique case (sel)
				2'b00: w = DTC_WAIT_BASE_HIT0;
				2'b01: w = DTC_WAIT_BASE_HIT1;
				default: w = DTC_WAIT_BASE_HIT2;
			endcase
		end
		return w;
	endfunction

	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		if (!s_r.busy) begin
			if (cfg.cycle_start) begin
				// Settings are sampled only here, so a write never alters a running access.
				s_nxt.waits = dtc_waits(cfg.wait_select, cfg.page_miss, cfg.page_miss_extra_wait);
				s_nxt.sub = 2'h0;
				s_nxt.busy = 1'b1;
			end
		end else if (s_r.waits == 3'h0) begin
			s_nxt.busy = 1'b0;
			s_nxt.done = 1'b1;
		end else if (s_r.sub == 2'(DTC_PERIODS_PER_WAIT - 2'h1)) begin
			s_nxt.sub = 2'h0;
			s_nxt.waits = 3'(s_r.waits - 3'h1);
		end else begin
			s_nxt.sub = 2'(s_r.sub + 2'h1);
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign cfg.busy = s_r.busy;
	assign cfg.wait_done = s_r.done;
endmodule // dtc_wait_counter

// [verilog/dtc_top.sv]
`timescale 1ns/1ps
module dtc_top (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [dtc_pkg::DTC_ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic addr_strap_six,
	input wire logic cycle_start,
	input wire logic page_miss,
	input wire logic bank_miss,
	output logic cycle_busy,
	output logic cycle_done,
	output logic page_mode_en,
	output logic parity_en,
	output logic two_row_strobes
);
	import dtc_pkg::*;

	typedef struct packed {
		logic [7:0] opt;
		logic [7:0] rdata;
		logic strap_s1;
		logic strap_s2;
		logic in_reset;
		logic page_mode_en;
		logic parity_en;
		logic two_rs;
		logic busy;
		logic done;
	} dtc_state_t;

	dtc_state_t s_r;
	dtc_state_t s_nxt;
	dtc_cfg_if cfg_bus ();

	// =========================================
	// Wait-state timing.
	assign cfg_bus.wait_select = s_r.opt[DTC_BIT_WS_HI:DTC_BIT_WS_LO];
	assign cfg_bus.page_miss_extra_wait = s_r.opt[DTC_BIT_PM_EXTRA];
	assign cfg_bus.cycle_start = cycle_start;
	assign cfg_bus.page_miss = page_miss;

	dtc_wait_counter u_cnt (
		.clk(clk),
		.rstn(rstn),
		.cfg(cfg_bus)
	);

	// =========================================
	// Register file and option outputs.
	always_comb begin
		s_nxt = s_r;
		// Strap pin is asynchronous; it passes two flops before use.
		s_nxt.strap_s1 = addr_strap_six;
		s_nxt.strap_s2 = s_r.strap_s1;
		s_nxt.in_reset = 1'b0;
		s_nxt.rdata = 8'h00;
		if (s_r.in_reset) begin
			s_nxt.opt[DTC_BIT_PAGE_DIS] = s_r.strap_s2;
		end
		if (reg_wr && reg_addr == DTC_ADDR_OPTIONS) begin
			s_nxt.opt = reg_wdata & DTC_OPT_WMASK;
		end
		if (reg_rd) begin
			unique case (reg_addr)
				DTC_ADDR_OPTIONS: s_nxt.rdata = s_r.opt;
				DTC_ADDR_STATUS: s_nxt.rdata = {6'h00, s_r.done, s_r.busy};
				default: s_nxt.rdata = 8'h00;
			endcase
		end
		// Output options are latched only between accesses; during a running cycle only two_rs can change, clearing when bank_miss falls.
		if (!cfg_bus.busy) begin
			s_nxt.page_mode_en = ~s_r.opt[DTC_BIT_PAGE_DIS];
			s_nxt.parity_en = ~s_r.opt[DTC_BIT_PAR_DIS];
			s_nxt.two_rs = bank_miss & ~s_r.opt[DTC_BIT_RAS_OFF];
		end else if (!bank_miss) begin
			s_nxt.two_rs = 1'b0;
		end
		s_nxt.busy = cfg_bus.busy;
		s_nxt.done = cfg_bus.wait_done;
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			s_r.opt <= DTC_OPT_RESET;
			s_r.rdata <= 8'h00;
			s_r.in_reset <= 1'b1;
			s_r.page_mode_en <= 1'b1;
			s_r.parity_en <= 1'b1;
			s_r.two_rs <= 1'b0;
			s_r.busy <= 1'b0;
			s_r.done <= 1'b0;
			// Synchroniser keeps running in reset so the strap is valid at release.
			s_r.strap_s1 <= addr_strap_six;
			s_r.strap_s2 <= s_r.strap_s1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign reg_rdata = s_r.rdata;
	assign cycle_busy = s_r.busy;
	assign cycle_done = s_r.done;
	assign page_mode_en = s_r.page_mode_en;
	assign parity_en = s_r.parity_en;
	assign two_row_strobes = s_r.two_rs;
endmodule // dtc_top

// [verif/dtc_assertions.sv]
`timescale 1ns/1ps
module dtc_assertions (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [dtc_pkg::DTC_ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic addr_strap_six,
	input wire logic cycle_start,
	input wire logic bank_miss,
	input wire logic cycle_busy,
	input wire logic cycle_done,
	input wire logic page_mode_en,
	input wire logic parity_en,
	input wire logic two_row_strobes
);
	import dtc_pkg::*;
	// ==========
	// Checks.
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence opt_wr;
		reg_wr && reg_addr == DTC_ADDR_OPTIONS ##1 !cycle_busy [*2];
	endsequence
	AST_PAGE: assert property (opt_wr |-> page_mode_en == !$past(reg_wdata[2], 2)) else $error("page");
	AST_PARITY: assert property (opt_wr |-> parity_en == !$past(reg_wdata[1], 2)) else $error("parity");
	AST_ROWS: assert property (opt_wr |-> two_row_strobes == ($past(bank_miss) && !$past(reg_wdata[0], 2)))
		else $error("rows");
	// A setting that moved in mid-access would stretch or cut the access.
	AST_HOLD: assert property (cycle_busy |-> $stable({page_mode_en, parity_en}) && !$rose(two_row_strobes))
		else $error("hold");
	AST_MISS: assert property (two_row_strobes |-> $past(bank_miss)) else $error("miss");
	AST_DONE: assert property (cycle_done |=> !cycle_done) else $error("done");
	AST_STRAP: assert property ($rose(rstn) |-> ##3 page_mode_en == !addr_strap_six) else $error("strap");
	AST_RESET: assert property ($rose(rstn) |-> ##3 parity_en && two_row_strobes == $past(bank_miss))
		else $error("reset");
	AST_RDHI: assert property (reg_rd && reg_addr == DTC_ADDR_OPTIONS |=> reg_rdata[7:6] == 2'h0)
		else $error("read");
	cover property (opt_wr);
	cover property (cycle_done);
	cover property (cycle_busy && two_row_strobes);
	cover property ($rose(rstn) ##3 !page_mode_en);
endmodule // dtc_assertions
bind dtc_top dtc_assertions u_chk (.*);

// [verif/dtc_dram_model.sv]
`timescale 1ns/1ps
module dtc_dram_model (
	input wire logic clk,
	input wire logic cycle_done,
	output logic cycle_start,
	output logic page_miss,
	output logic bank_miss
);
	// ==========
	// Access requester.
	initial {cycle_start, page_miss, bank_miss} = 3'h0;
	// The page_miss line shows its inverse once sampled, so a late read of it is caught.
	task automatic access(logic m, int gap);
		int n = 0;
		repeat (gap) @(posedge clk);
		@(posedge clk);
		{cycle_start, page_miss, bank_miss} <= {1'b1, m, m};
		@(posedge clk);
		{cycle_start, page_miss} <= {1'b0, ~m};
		while (cycle_done !== 1'b1 && n < 40) begin
			@(posedge clk);
			n++;
		end
		bank_miss <= 1'b0;
	endtask
endmodule // dtc_dram_model

// [verif/tb.sv]
`timescale 1ns/1ps
module tb;
	import dtc_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [DTC_ADDR_W-1:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic addr_strap_six = 1'b0;
	logic rd_p = 1'b0;
	logic [7:0] t = 8'h00;
	logic [7:0] reg_rdata;
	logic cycle_start, page_miss, bank_miss, cycle_busy, cycle_done, page_mode_en, parity_en, two_row_strobes;
	logic [7:0] rq[$];
	logic [7:0] lq[$];
	logic [7:0] oq[$];
	logic [7:0] opts;
	int n_mismatch = 0;
	int n_checks = 0;
	int cyc = 0;
	always #2 clk = ~clk;
	dtc_top dut (.*);
	dtc_dram_model m (.*);
	assign opts = {5'h00, page_mode_en, parity_en, two_row_strobes};
	// ==========
	// Tasks.
	task give_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task chk(string n, logic [7:0] e, logic [7:0] s);
		n_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task wr(logic [3:0] a, logic [7:0] d);
		@(posedge clk);
		{reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rd(logic [3:0] a, logic [7:0] e);
		rq.push_back(e);
		@(posedge clk);
		{reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask
	function automatic logic [7:0] lat(logic [7:0] v, logic p);
		logic [2:0] w;
		w = v[5] ? 3'h2 : {2'h0, v[4]};
		if (p) w = v[5] ? 3'(3'h4 + v[3]) : (v[4] ? 3'h3 : 3'(3'h2 + v[3]));
		return {4'h0, w, 1'b0} + 8'h03;
	endfunction
	always @(posedge clk) begin
		cyc++;
		t++;
		if (cycle_start === 1'b1) t = 8'h00;
		if (cycle_done === 1'b1) chk("latency", lq.pop_front(), t);
		if (cycle_done === 1'b1) chk("options", oq.pop_front(), opts);
		if (rd_p) chk("rdata", rq.pop_front(), reg_rdata);
		rd_p = reg_rd;
		if (cyc > 5000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	initial begin
		logic [7:0] v, w;
		void'($urandom(32'hF75F));
		addr_strap_six <= 1'($urandom);
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		rd(4'h0, {5'h00, addr_strap_six, 2'h0});
		for (int i = 0; i < 8; i++) begin
			v = {2'($urandom), 3'(i), 3'($urandom)};
			wr(4'h0, v);
			rd(4'h0, v & DTC_OPT_WMASK);
			wr(4'h1, ~v);
			rd(4'h0, v & DTC_OPT_WMASK);
			for (int k = 0; k < 2; k++) begin
				lq.push_back(lat(v, 1'(k)));
				oq.push_back({5'h00, ~v[2:1], 1'(k) & ~v[0]});
				m.access(1'(k), $urandom_range(3));
			end
		end
		// A write landing with the start must leave this access on the old timing.
		w = {5'h00, ~v[2:0]};
		lq.push_back(lat(v, 1'b1));
		oq.push_back({5'h00, ~w[2:0]});
		fork
			m.access(1'b1, 0);
			wr(4'h0, w);
			begin
				repeat (2) @(posedge clk);
				rd(4'h1, 8'h01);
			end
		join
		lq.push_back(lat(w, 1'b1));
		oq.push_back({5'h00, ~w[2:0]});
		m.access(1'b1, 2);
		repeat (4) @(posedge clk);
		chk("pending", 8'h00, 8'(lq.size() + oq.size() + rq.size()));
		give_verdict();
	end
endmodule // tb
